//--- prc_code_if.sv
// prc_code_if.sv: one register code and its classification
`default_nettype none
interface prc_code_if;
  logic [6:0]              code;
  prc_pkg::prc_reg_class_t cls;
  logic                    reserved;
  logic                    read_only;
  logic                    reads_zero;
  logic                    upper;
  modport dec (output code, input cls, reserved, read_only, reads_zero,
               upper);
  modport clsf (input code, output cls, reserved, read_only, reads_zero,
                upper);
endinterface : prc_code_if
`default_nettype wire

//--- prc_consts.svh
// prc_consts.svh: bank codes, register codes and slot indices of the decoder
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH

`define PRC_BANK_ADDR_LO   4'h0
`define PRC_BANK_ADDR_HI   4'h1
`define PRC_BANK_INDEX_LO  4'h2
`define PRC_BANK_INDEX_HI  4'h3
`define PRC_BANK_DATA      4'h4
`define PRC_BANK_STATUS    4'h5
`define PRC_BANK_CTRL      4'h7
`define PRC_BANK_LOOP_CNT  4'hC
`define PRC_BANK_LOOP_RSE  4'hD
`define PRC_BANK_LOOP_SE   4'hE
`define PRC_BANK_TAG       4'hF
`define PRC_BANK_MSB       3
`define PRC_REG_SP         3'h6
`define PRC_REG_ZERO       3'h7
`define PRC_REG_HALF       2

`define PRC_NUM_SLOTS      12
`define PRC_SLOT_ALU_DST   0
`define PRC_SLOT_ALU_SRC1  1
`define PRC_SLOT_ALU_SRC2  2
`define PRC_SLOT_MPY_SRC   3
`define PRC_SLOT_MOVE_SRC  4
`define PRC_SLOT_MOVE_DST  5
`define PRC_SLOT_GLB_SD    6
`define PRC_SLOT_LOC_SD    7
`define PRC_SLOT_GLB_ADDR  8
`define PRC_SLOT_LOC_ADDR  9
`define PRC_SLOT_GLB_IDX   10
`define PRC_SLOT_LOC_IDX   11

`endif

//--- prc_fetch_model.sv
// prc_fetch_model.sv: fetch stage model that presents decoded fields
`default_nettype none
module prc_fetch_model (
  input  wire logic                clk,             // decoder clock
  output var logic                 instr_valid,     // fields valid
  output var prc_pkg::prc_fmt_t    fmt,             // transfer format
  output var logic [11:0][2:0]     slot_reg,        // register fields
  output var logic [11:0][3:0]     slot_bank,       // bank fields
  output var logic [11:0]          slot_bank_full,  // 4-bit bank present
  output var logic [11:0]          slot_bank_short  // 3-bit bank present
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [11:0][2:0] st_reg;
  logic [11:0][3:0] st_bank;
  logic [11:0]      st_full;
  logic [11:0]      st_short;

  task automatic clear_slots();
    st_reg = '0;
    st_bank = '0;
    st_full = '0;
    st_short = '0;
  endtask

  task automatic set_slot(input int s, input logic [2:0] r,
                          input logic [3:0] b, input logic f,
                          input logic sh);
    st_reg[s] = r;
    st_bank[s] = b;
    st_full[s] = f;
    st_short[s] = sh;
  endtask

  // fields change only at the falling edge and stay put over the rising edge that takes them
  task automatic issue(input prc_pkg::prc_fmt_t f);
    @(negedge clk);
    instr_valid <= 1'b1;
    fmt <= f;
    slot_reg <= st_reg;
    slot_bank <= st_bank;
    slot_bank_full <= st_full;
    slot_bank_short <= st_short;
  endtask

  // released fields flip so a decoder that samples them anyway is caught
  task automatic release_bus();
    @(negedge clk);
    instr_valid <= 1'b0;
    fmt <= prc_pkg::prc_fmt_t'(~fmt);
    slot_reg <= ~slot_reg;
    slot_bank <= ~slot_bank;
    slot_bank_full <= ~slot_bank_full;
    slot_bank_short <= ~slot_bank_short;
  endtask

  initial begin
    clear_slots();
    instr_valid = 1'b0;
    fmt = prc_pkg::PRC_FMT_DOUBLE;
    slot_reg = '0;
    slot_bank = '0;
    slot_bank_full = '0;
    slot_bank_short = '0;
  end
endmodule // prc_fetch_model
`default_nettype wire

//--- prc_pkg.sv
// prc_pkg.sv: types shared by the register code decoder
`default_nettype none
package prc_pkg;
  typedef enum logic [3:0] {
    PRC_FMT_DOUBLE,
    PRC_FMT_MOVE_LOCAL,
    PRC_FMT_FIELD_LOCAL,
    PRC_FMT_GLOBAL_LONG,
    PRC_FMT_LOCAL_LONG,
    PRC_FMT_NOND_LOCAL,
    PRC_FMT_COND_MOVE,
    PRC_FMT_COND_FIELD,
    PRC_FMT_COND_GLOBAL,
    PRC_FMT_COND_NOND,
    PRC_FMT_IMM32
  } prc_fmt_t;

  typedef enum logic [1:0] {
    PRC_SRC1_D,
    PRC_SRC1_ANY,
    PRC_SRC1_LOWER
  } prc_src1_t;

  typedef enum logic [4:0] {
    PRC_CLS_ADDR, PRC_CLS_STACK_PTR, PRC_CLS_ZERO, PRC_CLS_INDEX,
    PRC_CLS_DATA, PRC_CLS_STATUS_REG, PRC_CLS_MULTI_FLAGS,
    PRC_CLS_PROGRAM_COUNTER_CALL, PRC_CLS_BRANCH_ADDR, PRC_CLS_EXEC_ADDR,
    PRC_CLS_RET_STATUS, PRC_CLS_INT_EN, PRC_CLS_INT_FLAG, PRC_CLS_COMM,
    PRC_CLS_LOOP_CTL, PRC_CLS_LOOP_CNT, PRC_CLS_LOOP_RELOAD,
    PRC_CLS_LOOP_RSE, PRC_CLS_LOOP_RS, PRC_CLS_LOOP_START,
    PRC_CLS_LOOP_END, PRC_CLS_CACHE_TAG, PRC_CLS_RESERVED
  } prc_reg_class_t;

  typedef struct packed {
    logic      alu_dst_any;
    prc_src1_t alu_src1;
    logic      cond;
    logic      prot;
    logic      move;
    logic      move_src_d;
    logic      glb;
    logic      glb_sd_lower;
    logic      glb_rel;
    logic      loc;
    logic      loc_sd_any;
    logic      loc_rel;
    logic      long_idx;
  } prc_fmt_caps_t;
endpackage : prc_pkg
`default_nettype wire

//--- prc_reg_classify.sv
// prc_reg_classify.sv: maps a 7-bit register code to its register class
`include "prc_consts.svh"
`default_nettype none
module prc_reg_classify (
  prc_code_if.clsf cif  // code in, class out
);
  logic [3:0] bank;
  logic [2:0] rsel;
  assign bank = cif.code[6:3];
  assign rsel = cif.code[2:0];
  assign cif.upper = bank[`PRC_BANK_MSB];

  always_comb begin
    cif.cls = prc_pkg::PRC_CLS_RESERVED;
    if (bank == `PRC_BANK_ADDR_LO ||
        bank == `PRC_BANK_ADDR_HI) begin
      if (rsel == `PRC_REG_SP) cif.cls = prc_pkg::PRC_CLS_STACK_PTR;
      else if (rsel == `PRC_REG_ZERO) cif.cls = prc_pkg::PRC_CLS_ZERO;
      else if (rsel != 3'h5) cif.cls = prc_pkg::PRC_CLS_ADDR;
    end else if (bank == `PRC_BANK_INDEX_LO ||
                 bank == `PRC_BANK_INDEX_HI) begin
      if (rsel <= 3'h2) cif.cls = prc_pkg::PRC_CLS_INDEX;
    end else if (bank == `PRC_BANK_DATA) begin
      cif.cls = prc_pkg::PRC_CLS_DATA;
    end else if (bank == `PRC_BANK_STATUS) begin
      if (rsel == 3'h1) cif.cls = prc_pkg::PRC_CLS_STATUS_REG;
      else if (rsel == 3'h2) cif.cls = prc_pkg::PRC_CLS_MULTI_FLAGS;
    end else if (bank == `PRC_BANK_CTRL) begin
      case (rsel)
        3'h0: cif.cls = prc_pkg::PRC_CLS_PROGRAM_COUNTER_CALL;
        3'h1: cif.cls = prc_pkg::PRC_CLS_BRANCH_ADDR;
        3'h2: cif.cls = prc_pkg::PRC_CLS_EXEC_ADDR;
        3'h3: cif.cls = prc_pkg::PRC_CLS_RET_STATUS;
        3'h4: cif.cls = prc_pkg::PRC_CLS_INT_EN;
        3'h5: cif.cls = prc_pkg::PRC_CLS_INT_FLAG;
        3'h6: cif.cls = prc_pkg::PRC_CLS_COMM;
        default: cif.cls = prc_pkg::PRC_CLS_LOOP_CTL;
      endcase
    end else if (rsel[1:0] != 2'h3) begin
      // low half of a loop bank is counters/RSE/starts, high half reloads/RS/ends
      if (bank == `PRC_BANK_LOOP_CNT) begin
        cif.cls = rsel[`PRC_REG_HALF] ? prc_pkg::PRC_CLS_LOOP_RELOAD
                                      : prc_pkg::PRC_CLS_LOOP_CNT;
      end else if (bank == `PRC_BANK_LOOP_RSE) begin
        cif.cls = rsel[`PRC_REG_HALF] ? prc_pkg::PRC_CLS_LOOP_RS
                                      : prc_pkg::PRC_CLS_LOOP_RSE;
      end else if (bank == `PRC_BANK_LOOP_SE) begin
        cif.cls = rsel[`PRC_REG_HALF] ? prc_pkg::PRC_CLS_LOOP_END
                                      : prc_pkg::PRC_CLS_LOOP_START;
      end
    end
    if (bank == `PRC_BANK_TAG && rsel[`PRC_REG_HALF]) begin
      cif.cls = prc_pkg::PRC_CLS_CACHE_TAG;
    end
  end

  assign cif.reserved   = (cif.cls == prc_pkg::PRC_CLS_RESERVED);
  assign cif.read_only  = (cif.cls == prc_pkg::PRC_CLS_EXEC_ADDR) ||
                          (cif.cls == prc_pkg::PRC_CLS_CACHE_TAG);
  // reserved codes read back zero: undefined to software, but harmless
  assign cif.reads_zero = (cif.cls == prc_pkg::PRC_CLS_ZERO) ||
                          cif.reserved;
endmodule // prc_reg_classify
`default_nettype wire

//--- prc_register_code_decoder.sv
// prc_register_code_decoder.sv: top of the register code decoder
//
// How it works
// - bank nibble above register field: 7-bit code
// - all 3-bit operand fields give low code bits
// - bank fields supply upper bits when present, unless the slot or format forces data bank or a zero MSB
// - no bank field selects data bank 0100
// - three-bit bank fields get MSB forced zero
// - bank MSB picks lower or upper group
// - banks 0-1 address, 2-3 index, sp, zero
// - bank 0111 maps eight control registers
// - bank 1100 low codes loop counters
// - bank 1100 high codes loop reloads
// - bank 1101 combined reload/start(/end) access
// - bank 1110 loop start and end addresses
// - bank 1111 high codes read-only cache tags
// - eleven formats restrict operands and transfers
// - condition and protection only in listed formats
// - relative addressing and long index per format
// - short source-1 bank is code bits 5-3
`include "prc_consts.svh"
`default_nettype none
module prc_register_code_decoder #(
  parameter int NUM_SLOTS = `PRC_NUM_SLOTS
) (
  input  wire logic                        clk,             // 10 MHz clock
  input  wire logic                        rst_n,           // sync reset
  input  wire logic                        instr_valid,     // fields valid
  input  wire prc_pkg::prc_fmt_t           fmt,             // transfer fmt
  input  wire logic [NUM_SLOTS-1:0][2:0]   slot_reg,        // reg fields
  input  wire logic [NUM_SLOTS-1:0][3:0]   slot_bank,       // bank fields
  input  wire logic [NUM_SLOTS-1:0]        slot_bank_full,  // 4-bit bank
  input  wire logic [NUM_SLOTS-1:0]        slot_bank_short, // 3-bit bank
  output logic                             out_valid_q,     // decode done
  output logic [NUM_SLOTS-1:0][6:0]        code_q,          // full codes
  output prc_pkg::prc_reg_class_t [NUM_SLOTS-1:0] class_q,  // reg class
  output logic [NUM_SLOTS-1:0]             upper_q,         // upper group
  output logic [NUM_SLOTS-1:0]             used_q,          // slot in use
  output logic [NUM_SLOTS-1:0]             reserved_q,      // reserved
  output logic [NUM_SLOTS-1:0]             read_only_q,     // read only
  output logic [NUM_SLOTS-1:0]             reads_zero_q,    // reads 0
  output logic [NUM_SLOTS-1:0]             write_ok_q,      // may write
  output logic                             illegal_q,       // bad select
  output logic                             cond_ok_q,       // cond honoured
  output logic                             prot_ok_q,       // status prot
  output logic                             move_en_q,       // move enabled
  output logic                             glb_en_q,        // global xfer
  output logic                             loc_en_q,        // local xfer
  output logic                             glb_rel_q,       // global rel
  output logic                             loc_rel_q,       // local rel
  output logic                             long_idx_q       // long offset
);

  // ************************************************************
  // format capabilities
  // ************************************************************
  function automatic prc_pkg::prc_fmt_caps_t fmt_caps(
    input prc_pkg::prc_fmt_t f
  );
    prc_pkg::prc_fmt_caps_t c;
    c = '0;
    c.alu_src1 = prc_pkg::PRC_SRC1_D;
    case (f)
      prc_pkg::PRC_FMT_DOUBLE: begin
        c.glb          = 1'b1;
        c.glb_sd_lower = 1'b1;
        c.loc          = 1'b1;
      end
      prc_pkg::PRC_FMT_MOVE_LOCAL: begin
        c.move    = 1'b1;
        c.loc     = 1'b1;
        c.loc_rel = 1'b1;
      end
      prc_pkg::PRC_FMT_FIELD_LOCAL: begin
        c.move       = 1'b1;
        c.move_src_d = 1'b1;
        c.loc        = 1'b1;
      end
      prc_pkg::PRC_FMT_GLOBAL_LONG: begin
        c.glb      = 1'b1;
        c.glb_rel  = 1'b1;
        c.long_idx = 1'b1;
      end
      prc_pkg::PRC_FMT_LOCAL_LONG: begin
        c.loc        = 1'b1;
        c.loc_sd_any = 1'b1;
        c.loc_rel    = 1'b1;
        c.long_idx   = 1'b1;
      end
      prc_pkg::PRC_FMT_NOND_LOCAL: begin
        c.alu_dst_any = 1'b1;
        c.alu_src1    = prc_pkg::PRC_SRC1_ANY;
        c.loc         = 1'b1;
        c.loc_rel     = 1'b1;
      end
      prc_pkg::PRC_FMT_COND_MOVE: begin
        c.cond = 1'b1;
        c.prot = 1'b1;
        c.move = 1'b1;
      end
      prc_pkg::PRC_FMT_COND_FIELD: begin
        c.cond       = 1'b1;
        c.prot       = 1'b1;
        c.move       = 1'b1;
        c.move_src_d = 1'b1;
      end
      prc_pkg::PRC_FMT_COND_GLOBAL: begin
        c.cond    = 1'b1;
        c.prot    = 1'b1;
        c.glb     = 1'b1;
        c.glb_rel = 1'b1;
      end
      prc_pkg::PRC_FMT_COND_NOND: begin
        c.alu_dst_any = 1'b1;
        c.alu_src1    = prc_pkg::PRC_SRC1_ANY;
        c.cond        = 1'b1;
        c.prot        = 1'b1;
      end
      prc_pkg::PRC_FMT_IMM32: begin
        // immediate takes the transfer bits: no transfer at all
        c.alu_dst_any = 1'b1;
        c.alu_src1    = prc_pkg::PRC_SRC1_LOWER;
        c.cond        = 1'b1;
      end
      default: c = '0;
    endcase
    return c;
  endfunction

  // ************************************************************
  // bank selection per operand slot
  // ************************************************************
  function automatic logic [3:0] eff_bank(
    input int                     s,
    input prc_pkg::prc_fmt_caps_t c,
    input logic                   full,
    input logic                   short_b,
    input logic [3:0]             bank
  );
    logic [3:0] b;
    b = `PRC_BANK_DATA;
    if (full) begin
      b = bank;
    end else if (short_b) begin
      b = {1'b0, bank[2:0]};
    end
    if (s == `PRC_SLOT_ALU_DST && !c.alu_dst_any) begin
      b = `PRC_BANK_DATA;
    end else if (s == `PRC_SLOT_ALU_SRC1) begin
      if (c.alu_src1 == prc_pkg::PRC_SRC1_D) begin
        b = `PRC_BANK_DATA;
      end else if (c.alu_src1 == prc_pkg::PRC_SRC1_LOWER) begin
        b[`PRC_BANK_MSB] = 1'b0;
      end
    end else if (s == `PRC_SLOT_ALU_SRC2 || s == `PRC_SLOT_MPY_SRC) begin
      b = `PRC_BANK_DATA;
    end else if (s == `PRC_SLOT_MOVE_SRC && c.move_src_d) begin
      b = `PRC_BANK_DATA;
    end else if (s == `PRC_SLOT_GLB_SD && c.glb_sd_lower) begin
      b[`PRC_BANK_MSB] = 1'b0;
    end else if (s == `PRC_SLOT_LOC_SD && !c.loc_sd_any) begin
      b = `PRC_BANK_DATA;
    end
    return b;
  endfunction

  function automatic logic slot_used(
    input int                     s,
    input prc_pkg::prc_fmt_caps_t c
  );
    logic u;
    u = 1'b1;
    if (s == `PRC_SLOT_MOVE_SRC || s == `PRC_SLOT_MOVE_DST) begin
      u = c.move;
    end else if (s == `PRC_SLOT_GLB_SD || s == `PRC_SLOT_GLB_ADDR ||
                 s == `PRC_SLOT_GLB_IDX) begin
      u = c.glb;
    end else if (s == `PRC_SLOT_LOC_SD || s == `PRC_SLOT_LOC_ADDR ||
                 s == `PRC_SLOT_LOC_IDX) begin
      u = c.loc;
    end
    return u;
  endfunction

  prc_pkg::prc_fmt_caps_t caps;
  assign caps = fmt_caps(fmt);

  logic [NUM_SLOTS-1:0] used_d;
  logic [NUM_SLOTS-1:0] reserved_d;
  logic [NUM_SLOTS-1:0] read_only_d;
  logic [NUM_SLOTS-1:0] reads_zero_d;
  logic [NUM_SLOTS-1:0] upper_d;
  logic [NUM_SLOTS-1:0][6:0] code_d;
  prc_pkg::prc_reg_class_t [NUM_SLOTS-1:0] class_d;

  // ************************************************************
  // per-slot code build and classification
  // ************************************************************
  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
    prc_code_if slot_if ();
    assign slot_if.code = {eff_bank(i, caps, slot_bank_full[i],
                                    slot_bank_short[i], slot_bank[i]),
                           slot_reg[i]};
    prc_reg_classify u_cls (
      .cif (slot_if)
    );
    assign code_d[i]       = slot_if.code;
    assign class_d[i]      = slot_if.cls;
    assign reserved_d[i]   = slot_if.reserved;
    assign read_only_d[i]  = slot_if.read_only;
    assign reads_zero_d[i] = slot_if.reads_zero;
    assign upper_d[i]      = slot_if.upper;
    assign used_d[i]       = slot_used(i, caps);
  end

  // ************************************************************
  // registered results
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= instr_valid;
    end
  end

  // results hold between instructions so the datapath sees stable codes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_q       <= '0;
      class_q      <= '{default: prc_pkg::PRC_CLS_ADDR};
      upper_q      <= '0;
      used_q       <= '0;
      reserved_q   <= '0;
      read_only_q  <= '0;
      reads_zero_q <= '0;
      write_ok_q   <= '0;
      illegal_q    <= 1'b0;
    end else if (instr_valid) begin
      code_q       <= code_d;
      class_q      <= class_d;
      upper_q      <= upper_d;
      used_q       <= used_d;
      reserved_q   <= reserved_d;
      read_only_q  <= read_only_d;
      reads_zero_q <= reads_zero_d;
      write_ok_q   <= used_d & ~reserved_d & ~read_only_d &
                      ~reads_zero_d;
      illegal_q    <= |(used_d & reserved_d);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cond_ok_q  <= 1'b0;
      prot_ok_q  <= 1'b0;
      move_en_q  <= 1'b0;
      glb_en_q   <= 1'b0;
      loc_en_q   <= 1'b0;
      glb_rel_q  <= 1'b0;
      loc_rel_q  <= 1'b0;
      long_idx_q <= 1'b0;
    end else if (instr_valid) begin
      cond_ok_q  <= caps.cond;
      prot_ok_q  <= caps.prot;
      move_en_q  <= caps.move;
      glb_en_q   <= caps.glb;
      loc_en_q   <= caps.loc;
      glb_rel_q  <= caps.glb_rel;
      loc_rel_q  <= caps.loc_rel;
      long_idx_q <= caps.long_idx;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  code_low_bits_a:
    assert property (out_valid_q |->
      code_q[`PRC_SLOT_MOVE_DST][2:0] ==
      $past(slot_reg[`PRC_SLOT_MOVE_DST]))
    else $error("code low bits differ from register field");

  bank_taken_a:
    assert property ($past(instr_valid && slot_bank_full[`PRC_SLOT_MOVE_DST])
      |-> code_q[`PRC_SLOT_MOVE_DST][6:3] ==
          $past(slot_bank[`PRC_SLOT_MOVE_DST]))
    else $error("move destination bank not taken");

  default_bank_a:
    assert property (out_valid_q |->
      code_q[`PRC_SLOT_ALU_SRC2][6:3] == `PRC_BANK_DATA &&
      code_q[`PRC_SLOT_MPY_SRC][6:3] == `PRC_BANK_DATA)
    else $error("bankless field left data bank");

  short_bank_a:
    assert property ($past(instr_valid &&
      slot_bank_short[`PRC_SLOT_GLB_SD] && !slot_bank_full[`PRC_SLOT_GLB_SD])
      |-> !code_q[`PRC_SLOT_GLB_SD][6] && !upper_q[`PRC_SLOT_GLB_SD])
    else $error("short bank selected upper register");

  stack_ptr_a:
    assert property (out_valid_q &&
      code_q[`PRC_SLOT_MOVE_SRC][6:4] == 3'h0 &&
      code_q[`PRC_SLOT_MOVE_SRC][2:0] == `PRC_REG_SP |->
      class_q[`PRC_SLOT_MOVE_SRC] == prc_pkg::PRC_CLS_STACK_PTR)
    else $error("stack pointer code misclassified");

  tag_read_only_a:
    assert property (out_valid_q &&
      code_q[`PRC_SLOT_MOVE_SRC][6:2] == 5'h1F |->
      read_only_q[`PRC_SLOT_MOVE_SRC] && !write_ok_q[`PRC_SLOT_MOVE_SRC])
    else $error("cache tag writable");

  alu_dst_data_a:
    assert property ($past(instr_valid && fmt == prc_pkg::PRC_FMT_DOUBLE)
      |-> code_q[`PRC_SLOT_ALU_DST][6:3] == `PRC_BANK_DATA && glb_en_q &&
          loc_en_q && !move_en_q)
    else $error("double parallel operands or transfers wrong");

  imm_cond_a:
    assert property ($past(instr_valid && fmt == prc_pkg::PRC_FMT_IMM32)
      |-> cond_ok_q && !prot_ok_q && !glb_en_q && !loc_en_q)
    else $error("immediate format condition or protection wrong");

  global_long_a:
    assert property ($past(instr_valid && fmt == prc_pkg::PRC_FMT_GLOBAL_LONG)
      |-> glb_rel_q && long_idx_q && !loc_rel_q && !cond_ok_q)
    else $error("long global addressing flags wrong");

  reserved_illegal_a:
    assert property (out_valid_q && |(used_q & reserved_q) |->
      illegal_q && !(|(write_ok_q & reserved_q)))
    else $error("reserved selection not flagged");

endmodule // prc_register_code_decoder
`default_nettype wire

//--- prc_register_code_decoder_tb.sv
// prc_register_code_decoder_tb.sv: self-checking bench of the decoder
`default_nettype none
module prc_register_code_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // **********************************************************************
  // signals and instances
  // **********************************************************************
  localparam logic [7:0] CAPS [11] = '{8'h18, 8'h2A, 8'h28, 8'h15, 8'h0B,
                                       8'h0A, 8'hE0, 8'hE0, 8'hD4, 8'hC0,
                                       8'h80};
  logic clk, rst_n, instr_valid, out_valid_q, illegal_q, cond_ok_q;
  logic prot_ok_q, move_en_q, glb_en_q, loc_en_q, glb_rel_q, loc_rel_q;
  logic long_idx_q;
  prc_pkg::prc_fmt_t              fmt;
  logic [11:0][2:0]               slot_reg;
  logic [11:0][3:0]               slot_bank;
  logic [11:0]                    slot_bank_full, slot_bank_short;
  logic [11:0][6:0]               code_q;
  prc_pkg::prc_reg_class_t [11:0] class_q;
  logic [11:0] upper_q, used_q, reserved_q, read_only_q, reads_zero_q;
  logic [11:0] write_ok_q;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;

  prc_fetch_model fm (.clk(clk), .instr_valid(instr_valid), .fmt(fmt),
    .slot_reg(slot_reg), .slot_bank(slot_bank),
    .slot_bank_full(slot_bank_full), .slot_bank_short(slot_bank_short));

  prc_register_code_decoder #(.NUM_SLOTS(12)) dut (.clk(clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .fmt(fmt), .slot_reg(slot_reg),
    .slot_bank(slot_bank), .slot_bank_full(slot_bank_full),
    .slot_bank_short(slot_bank_short), .out_valid_q(out_valid_q),
    .code_q(code_q), .class_q(class_q), .upper_q(upper_q), .used_q(used_q),
    .reserved_q(reserved_q), .read_only_q(read_only_q),
    .reads_zero_q(reads_zero_q), .write_ok_q(write_ok_q),
    .illegal_q(illegal_q), .cond_ok_q(cond_ok_q), .prot_ok_q(prot_ok_q),
    .move_en_q(move_en_q), .glb_en_q(glb_en_q), .loc_en_q(loc_en_q),
    .glb_rel_q(glb_rel_q), .loc_rel_q(loc_rel_q), .long_idx_q(long_idx_q));

  // **********************************************************************
  // helpers
  // **********************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cls(input prc_pkg::prc_reg_class_t got,
                         input prc_pkg::prc_reg_class_t exp,
                         input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  function automatic prc_pkg::prc_reg_class_t exp_cls(input logic [6:0] c);
    logic [2:0] r;
    r = c[2:0];
    case (c[6:3])
      4'h0, 4'h1: begin
        if (r == 3'h5) return prc_pkg::PRC_CLS_RESERVED;
        if (r == 3'h6) return prc_pkg::PRC_CLS_STACK_PTR;
        if (r == 3'h7) return prc_pkg::PRC_CLS_ZERO;
        return prc_pkg::PRC_CLS_ADDR;
      end
      4'h2, 4'h3: if (r < 3'h3) return prc_pkg::PRC_CLS_INDEX;
      4'h4: return prc_pkg::PRC_CLS_DATA;
      4'h5: begin
        if (r == 3'h1) return prc_pkg::PRC_CLS_STATUS_REG;
        if (r == 3'h2) return prc_pkg::PRC_CLS_MULTI_FLAGS;
      end
      4'h7: return prc_pkg::prc_reg_class_t'(prc_pkg::PRC_CLS_PROGRAM_COUNTER_CALL + r);
      // loop banks: two classes per bank, split by reg bit 2
      4'hC, 4'hD, 4'hE: if (r[1:0] != 2'h3)
        return prc_pkg::prc_reg_class_t'(prc_pkg::PRC_CLS_LOOP_CNT
               + 2 * (c[6:3] - 4'hC) + r[2]);
      4'hF: if (r[2]) return prc_pkg::PRC_CLS_CACHE_TAG;
      default: ;
    endcase
    return prc_pkg::PRC_CLS_RESERVED;
  endfunction

  // result of a request is looked at 1 ns after the edge that takes it
  task automatic step(input prc_pkg::prc_fmt_t f);
    fm.issue(f);
    @(posedge clk);
    #1;
  endtask

  task automatic t_sweep();
    logic [6:0] c;
    prc_pkg::prc_reg_class_t e;
    logic res, ro, rz;
    for (int i = 0; i < 128; i++) begin
      c = 7'(i);
      e = exp_cls(c);
      res = (e == prc_pkg::PRC_CLS_RESERVED);
      ro = (c == 7'h3A) || (c[6:3] == 4'hF && c[2]);
      rz = res || (c[6:4] == 3'h0 && c[2:0] == 3'h7);
      fm.clear_slots();
      fm.set_slot(4, c[2:0], c[6:3], 1'b1, 1'b0);
      step(prc_pkg::PRC_FMT_MOVE_LOCAL);
      chk(8'(out_valid_q), 8'h01, "valid");
      chk(8'(code_q[4]), 8'(c), "code");
      chk_cls(class_q[4], e, "cls");
      chk(8'(upper_q[4]), 8'(c[6]), "upper");
      chk(8'(reads_zero_q[4]), 8'(rz), "zero");
      chk(8'(read_only_q[4]), 8'(ro), "ro");
      chk(8'({reserved_q[4], illegal_q}), 8'({res, res}), "rsv");
      chk(8'(write_ok_q[4]), 8'(!(res || ro || rz)), "wr");
    end
  endtask

  task automatic t_banks();
    fm.clear_slots();
    fm.set_slot(2, 3'h5, 4'hF, 1'b1, 1'b0);
    fm.set_slot(9, 3'h3, 4'hF, 1'b0, 1'b0);
    fm.set_slot(6, 3'h2, 4'hF, 1'b0, 1'b1);
    // formats that do not clear the msb themselves, so the short path shows
    step(prc_pkg::PRC_FMT_GLOBAL_LONG);
    chk(8'(code_q[2]), 8'h25, "src2");
    chk(8'(code_q[9]), 8'h23, "laddr");
    chk(8'(code_q[6]), 8'h3A, "gshort");
    fm.set_slot(1, 3'h1, 4'hE, 1'b0, 1'b1);
    step(prc_pkg::PRC_FMT_NOND_LOCAL);
    chk(8'(code_q[1]), 8'h31, "s1short");
  endtask

  task automatic t_formats();
    prc_pkg::prc_fmt_t f;
    logic nd, im;
    logic [7:0] g, ed, es;
    for (int i = 0; i < 11; i++) begin
      f = prc_pkg::prc_fmt_t'(i);
      im = (f == prc_pkg::PRC_FMT_IMM32);
      nd = (f == prc_pkg::PRC_FMT_NOND_LOCAL ||
            f == prc_pkg::PRC_FMT_COND_NOND);
      // codes are {bank, reg}: 0111 011, 0100 011, 1101 001, 0101 001, ...
      ed = (nd || im) ? 8'h3B : 8'h23;
      es = nd ? 8'h69 : (im ? 8'h29 : 8'h21);
      fm.clear_slots();
      fm.set_slot(0, 3'h3, 4'h7, 1'b1, 1'b0);
      // bank 1101 so a forced msb shows up as a different code
      fm.set_slot(1, 3'h1, 4'hD, 1'b1, 1'b0);
      step(f);
      g = {cond_ok_q, prot_ok_q, move_en_q, glb_en_q, loc_en_q, glb_rel_q,
           loc_rel_q, long_idx_q};
      chk(g, CAPS[i], "caps");
      chk(8'({used_q[4], used_q[6], used_q[7]}), 8'(CAPS[i][5:3]), "use");
      chk(8'(code_q[0]), ed, "dst");
      chk(8'(code_q[1]), es, "src1");
    end
  endtask

  task automatic t_hold();
    fm.release_bus();
    @(posedge clk);
    #1;
    chk(8'(out_valid_q), 8'h00, "pulse");
    repeat (3) @(posedge clk);
    #1;
    chk(8'({cond_ok_q, code_q[1]}), 8'hA9, "hold");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // **********************************************************************
  // run
  // **********************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // the whole run needs about 150 cycles; far beyond that means a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      n_fail++;
      $display("FAIL %0t timeout", $time);
      summarize();
    end
  end

  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(8'({out_valid_q, illegal_q}), 8'h00, "reset");
    @(negedge clk);
    rst_n = 1'b1;
    t_sweep();
    t_banks();
    t_formats();
    t_hold();
    summarize();
  end
endmodule // prc_register_code_decoder_tb
`default_nettype wire
